// >>> src/olp_defs.svh
`ifndef OLP_DEFS_SVH
`define OLP_DEFS_SVH
// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define OLP_OR_IMM_HI 8'h09
`define OLP_OR_FILE_HI6 6'h04
`define OLP_PTR_LOAD_HI10 10'h3b8
`define OLP_PTR_SECOND_HI8 8'hf0
// ----------------------------------------
// Addressing
// ----------------------------------------
`define OLP_IDX_LIMIT 8'h5f
`define OLP_ACCESS_SPLIT 8'h60
`define OLP_ACC_RST 8'h00
`define OLP_PTR_COUNT 3
`endif

// >>> src/olp_pkg.sv
package olp_pkg;
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } olp_phase_t;

    typedef struct packed {
        logic sign;
        logic zero;
    } olp_flags_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [11:0] addr;
        logic [7:0] data;
    } olp_mem_t;
endpackage

// >>> src/olp_exec.sv
// Notes on behaviour
// - Literal OR into accumulator; sign, zero only
// - Literal OR is opcode byte 09 plus literal
// - File OR with accumulator; sign, zero flags
// - File OR: top bits 000100, d, a, address
// - d=0 to accumulator, d=1 to file
// - a=0 access bank, a=1 bank select
// - Extended mode, a=0, f<=95: indexed offset
// - Pointer load 12-bit literal, selector 0..2
`timescale 1ns/1ps
`include "olp_defs.svh"
module olp_exec (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic [15:0] instrWord,
    input wire logic extEnable,
    input wire logic [7:0] bankSelectReg,
    input wire logic [11:0] indexBase,
    input wire logic [7:0] memRdata,
    output olp_pkg::olp_mem_t memBus,
    output logic [7:0] accOut,
    output olp_pkg::olp_flags_t flagsOut,
    output logic [7:0] ptrHigh0,
    output logic [7:0] ptrLow0,
    output logic [7:0] ptrHigh1,
    output logic [7:0] ptrLow1,
    output logic [7:0] ptrHigh2,
    output logic [7:0] ptrLow2,
    output logic phaseStart
);
    import olp_pkg::*;

    // ----------------------------------------
    // Phase sequencing
    // ----------------------------------------
    olp_phase_t phase_q;
    logic [15:0] instr_q;
    logic secondWord_q;
    logic [1:0] ptrSel_q;
    logic [3:0] ptrNib_q;
    logic [7:0] acc_q;
    olp_flags_t flags_q;
    olp_mem_t mem_q;
    logic [7:0] result_q;
    logic [7:0] ptrH_q [0:2];
    logic [7:0] ptrL_q [0:2];
    logic start_q;

    // Decoded fields of the latched word
    logic isOrImm;
    logic isOrFile;
    logic isPtrLoad;
    logic destFile;
    logic bankMode;
    logic [7:0] fAddr;
    logic [11:0] effAddr;

    assign isOrImm = !secondWord_q && instr_q[15:8] == `OLP_OR_IMM_HI;
    assign isOrFile = !secondWord_q
        && instr_q[15:10] == `OLP_OR_FILE_HI6;
    // Selector 3 is undefined, so it is ignored as a no-op
    assign isPtrLoad = !secondWord_q
        && instr_q[15:6] == `OLP_PTR_LOAD_HI10
        && instr_q[5:4] != 2'd3;
    assign destFile = instr_q[9];
    assign bankMode = instr_q[8];
    assign fAddr = instr_q[7:0];

    always_comb begin
        effAddr = 12'h000;
        if (bankMode) begin
            effAddr = {bankSelectReg[3:0], fAddr};
        end else if (extEnable && fAddr <= `OLP_IDX_LIMIT) begin
            effAddr = indexBase + {4'h0, fAddr};
        end else if (fAddr < `OLP_ACCESS_SPLIT) begin
            effAddr = {4'h0, fAddr};
        end else begin
            effAddr = {4'hf, fAddr};
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            phase_q <= PH_DECODE;
            start_q <= 1'b0;
        end else if (clkEn) begin
            unique case (phase_q)
                PH_DECODE: phase_q <= PH_READ;
                PH_READ: phase_q <= PH_PROCESS;
                PH_PROCESS: phase_q <= PH_WRITE;
                PH_WRITE: phase_q <= PH_DECODE;
            endcase
            start_q <= phase_q == PH_WRITE;
        end
    end

    // ----------------------------------------
    // Instruction latch and pointer sequence
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            instr_q <= 16'h0000;
        end else if (clkEn && phase_q == PH_DECODE) begin
            instr_q <= instrWord;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            secondWord_q <= 1'b0;
            ptrSel_q <= 2'd0;
            ptrNib_q <= 4'h0;
        end else if (clkEn && phase_q == PH_WRITE) begin
            if (isPtrLoad) begin
                secondWord_q <= 1'b1;
                ptrSel_q <= instr_q[5:4];
                ptrNib_q <= instr_q[3:0];
            end else begin
                secondWord_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int i = 0; i < `OLP_PTR_COUNT; i++) begin
                ptrH_q[i] <= 8'h00;
                ptrL_q[i] <= 8'h00;
            end
        end else if (clkEn && phase_q == PH_WRITE) begin
            if (isPtrLoad) begin
                ptrH_q[instr_q[5:4]] <= {4'h0, instr_q[3:0]};
            end else if (secondWord_q
                && instr_q[15:8] == `OLP_PTR_SECOND_HI8) begin
                ptrL_q[ptrSel_q] <= instr_q[7:0];
            end
        end
    end

    // ----------------------------------------
    // Data memory access
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mem_q <= '0;
        end else if (clkEn) begin
            mem_q.req <= 1'b0;
            mem_q.wr <= 1'b0;
            if (phase_q == PH_DECODE) begin
                // Address held stable into the read phase
                if (instrWord[15:10] == `OLP_OR_FILE_HI6) begin
                    mem_q.req <= 1'b0;
                end
            end else if (phase_q == PH_READ && isOrFile) begin
                mem_q.req <= 1'b1;
                mem_q.addr <= effAddr;
            end else if (phase_q == PH_WRITE && isOrFile && destFile) begin
                mem_q.req <= 1'b1;
                mem_q.wr <= 1'b1;
                mem_q.addr <= effAddr;
                mem_q.data <= result_q;
            end
        end
    end

    // ----------------------------------------
    // OR datapath
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            result_q <= 8'h00;
        end else if (clkEn && phase_q == PH_PROCESS) begin
            if (isOrImm) begin
                result_q <= acc_q | instr_q[7:0];
            end else if (isOrFile) begin
                result_q <= acc_q | memRdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            acc_q <= `OLP_ACC_RST;
            flags_q <= '0;
        end else if (clkEn && phase_q == PH_WRITE) begin
            if (isOrImm || isOrFile) begin
                flags_q.sign <= result_q[7];
                flags_q.zero <= result_q == 8'h00;
            end
            if (isOrImm || (isOrFile && !destFile)) begin
                acc_q <= result_q;
            end
        end
    end

    assign memBus = mem_q;
    assign accOut = acc_q;
    assign flagsOut = flags_q;
    assign ptrHigh0 = ptrH_q[0];
    assign ptrLow0 = ptrL_q[0];
    assign ptrHigh1 = ptrH_q[1];
    assign ptrLow1 = ptrL_q[1];
    assign ptrHigh2 = ptrH_q[2];
    assign ptrLow2 = ptrL_q[2];
    assign phaseStart = start_q;
endmodule

// >>> bench/olp_exec_assertions.sv
`timescale 1ns/1ps
module olp_exec_assertions (
    input logic mclk,
    input logic nrst,
    input logic clkEn,
    input logic [15:0] instrWord,
    input logic [7:0] memRdata,
    input olp_pkg::olp_mem_t memBus,
    input logic [7:0] accOut,
    input olp_pkg::olp_flags_t flagsOut,
    input logic [7:0] ptrHigh2,
    input logic phaseStart
);
    import olp_pkg::*;
    // ------------
    // Checks
    // ------------
    logic [1:0] ph_q;
    logic pend_q;
    always_ff @(posedge mclk) begin
        if (!nrst) ph_q <= 2'h0;
        else if (clkEn) ph_q <= ph_q + 2'h1;
    end
    // Second pointer word pending; it never runs as an instruction
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pend_q <= 1'b0;
        end else if (clkEn && ph_q == 2'h0) begin
            pend_q <= !pend_q && instrWord[15:6] == 10'h3b8
                && instrWord[5:4] != 2'h3;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    AST_PERIOD: assert property (phaseStart |=>
        !phaseStart [*3] ##1 phaseStart) else $error("period");
    AST_READ_SLOT: assert property (memBus.req && !memBus.wr |->
        ph_q == 2'h2 && $past(instrWord[15:10], 2) == 6'h04) else $error("rd");
    AST_WRITE_SLOT: assert property (memBus.req && memBus.wr |->
        ph_q == 2'h0 && $past(instrWord[9], 4) && memBus.data ==
        ($past(accOut) | $past(memRdata, 2))) else $error("wr");
    AST_REQ_PULSE: assert property (memBus.req |=>
        !memBus.req) else $error("pulse");
    AST_LIT: assert property (!pend_q && ph_q == 2'h0 &&
        instrWord[15:8] == 8'h09 |-> ##4
        accOut == ($past(accOut, 4) | $past(instrWord[7:0], 4)) &&
        flagsOut == {accOut[7], accOut == 8'h00}) else $error("lit");
    AST_FILE: assert property (!pend_q && ph_q == 2'h0 &&
        instrWord[15:9] == 7'h08 |-> ##4
        accOut == ($past(accOut, 4) | $past(memRdata, 2)) &&
        flagsOut == {accOut[7], accOut == 8'h00}) else $error("file");
    AST_HOLD: assert property (ph_q == 2'h0 && (pend_q ||
        (instrWord[15:8] != 8'h09 && instrWord[15:10] != 6'h04)) |-> ##4
        $stable(accOut) && $stable(flagsOut)) else $error("hold");
    AST_PTR: assert property (!pend_q && ph_q == 2'h0 &&
        instrWord[15:4] == 12'hee2 |-> ##4
        ptrHigh2 == {4'h0, $past(instrWord[3:0], 4)}) else $error("ptr");
    cover property (memBus.req && memBus.wr);
    cover property (ph_q == 2'h0 && instrWord[15:4] == 12'hee2);
    cover property (memBus.req && !memBus.wr && memBus.addr[11:8] == 4'hf);
endmodule
bind olp_exec olp_exec_assertions u_chk (.mclk, .nrst, .clkEn, .instrWord,
    .memRdata, .memBus, .accOut, .flagsOut, .ptrHigh2, .phaseStart);

// >>> bench/test_olp_exec.sv
`timescale 1ns/1ps
module test_olp_exec;
    import olp_pkg::*;
    // ------------
    // Bench
    // ------------
    logic mclk = 0, nrst = 0, clkEn = 1, extEnable = 0, phaseStart, pend = 0;
    logic [15:0] instrWord = '0;
    logic [7:0] bankSelectReg = '0, memRdata = '0, accOut, mAcc = '0;
    logic [7:0] ptrHigh0, ptrLow0, ptrHigh1, ptrLow1, ptrHigh2, ptrLow2;
    logic [11:0] indexBase = '0, addrQ [$], ea;
    logic [47:0] mPtr = '0;
    logic [1:0] mFlg = '0, pSel = '0;
    logic [79:0] expQ [$], e, got;
    olp_mem_t memBus;
    olp_flags_t flagsOut;
    int error_cnt = 0, n_compared = 0, cyc = 0, seed = 23, i, k;
    always #12.5 mclk = ~mclk;
    olp_exec dut (.mclk, .nrst, .clkEn, .instrWord, .extEnable,
        .bankSelectReg, .indexBase, .memRdata, .memBus, .accOut, .flagsOut,
        .ptrHigh0, .ptrLow0, .ptrHigh1, .ptrLow1, .ptrHigh2, .ptrLow2,
        .phaseStart);
    task automatic check(input string nm, input logic [79:0] ex, gt);
        n_compared++;
        if (gt !== ex) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, ex, gt);
        end
    endtask
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Note is pushed one edge late so the monitor never pops it early
    task automatic exec(input logic [15:0] w, input logic [7:0] md,
        input logic [20:0] x);
        logic [7:0] r;
        logic [11:0] a;
        logic [21:0] wb;
        int n;
        n = 0;
        wb = '0;
        while (phaseStart !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1 n++;
        end
        {extEnable, bankSelectReg, indexBase} = x;
        instrWord = w;
        memRdata = md;
        r = mAcc | md;
        a = w[8] ? {bankSelectReg[3:0], w[7:0]} :
            (extEnable && w[7:0] <= 8'h5f) ? indexBase + w[7:0] :
            {{4{w[7:0] > 8'h5f}}, w[7:0]};
        // Second pointer word: only an f0 word counts, all else dropped
        if (pend) begin
            if (w[15:8] == 8'hf0) mPtr[8 * (4 - 2 * pSel) +: 8] = w[7:0];
        end else if (w[15:8] == 8'h09) begin
            mAcc = mAcc | w[7:0];
            mFlg = {mAcc[7], mAcc == 8'h00};
        end else if (w[15:10] == 6'h04) begin
            addrQ.push_back(a);
            mFlg = {r[7], r == 8'h00};
            if (w[9]) wb = {2'b11, a, r};
            else mAcc = r;
        end else if (w[15:6] == 10'h3b8 && w[5:4] != 2'h3) begin
            mPtr[8 * (5 - 2 * w[5:4]) +: 8] = {4'h0, w[3:0]};
        end
        pend = !pend && w[15:6] == 10'h3b8 && w[5:4] != 2'h3;
        pSel = w[5:4];
        @(posedge mclk);
        #1 expQ.push_back({mAcc, mFlg, mPtr, wb});
    endtask
    always @(negedge mclk) begin
        if (nrst && phaseStart === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            got = {accOut, flagsOut, ptrHigh0, ptrLow0, ptrHigh1, ptrLow1,
                ptrHigh2, ptrLow2, memBus};
            if (!e[21]) got[20:0] = e[20:0];
            check("state", e, got);
        end
        if (nrst && memBus.req === 1'b1 && memBus.wr === 1'b0
            && addrQ.size() > 0) begin
            ea = addrQ.pop_front();
            check("raddr", ea, memBus.addr);
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1 nrst = 1;
        exec(16'h0900, 8'h00, '0);
        exec(16'h0935, 8'h00, '0);
        exec(16'hee23, 8'h00, '0);
        exec(16'hf0ab, 8'h00, '0);
        exec(16'hee3f, 8'h00, '0);
        exec(16'h0000, 8'h00, '0);
        for (i = 0; i < 80; i++) begin
            k = $random(seed);
            case (i % 4)
                0: exec({8'h09, k[7:0]}, 8'h00, k[31:11]);
                1: exec({6'h04, k[9:8], i[2] ? 8'h5f + i[3] : k[7:0]},
                    k[31:24], k[31:11]);
                2: begin
                    exec({10'h3b8, k[5:0]}, 8'h00, '0);
                    exec({k[5:4] == 2'h3 || k[16] ? 8'h09 : 8'hf0,
                        k[15:8]}, 8'h00, '0);
                end
                default: exec({4'h5, k[11:0]}, 8'h00, '0);
            endcase
        end
        exec(16'h0000, 8'h00, '0);
        k = 0;
        while (expQ.size() != 0 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        close_out();
    end
endmodule
